/* pkg/tmin_pacing_pkg.sv */
// Constants shared by the dynamic minimum-temperature pacing logic
package tmin_pacing_pkg;
    // Register byte offsets on the slave port
    localparam logic [3:0]  ENABLE_OFFSET      = 4'h0;
    localparam logic [3:0]  PACING_OFFSET      = 4'h4;
    localparam logic [3:0]  STATUS_OFFSET      = 4'h8;

    // Field positions
    localparam int          REMOTE1_EN_BIT     = 0;
    localparam int          REMOTE2_EN_BIT     = 1;
    localparam int          REMOTE1_INT_LSB    = 0;
    localparam int          REMOTE2_INT_LSB    = 3;
    localparam int          LOOP_SELECT_BIT    = 6;
    localparam int          RESERVED_BIT       = 7;
    localparam int          INTERVAL_W         = 3;

    // Reset values and writable masks
    localparam logic [7:0]  ENABLE_RESET       = 8'h00;
    localparam logic [7:0]  ENABLE_WRITE_MASK  = 8'h03;
    localparam logic [7:0]  PACING_RESET       = 8'h40;
    localparam logic [7:0]  PACING_WRITE_MASK  = 8'h7f;

    // Wait series in monitoring cycles
    localparam int          WAIT_W             = 12;
    localparam logic [11:0] DEC_BASE_WAIT      = 12'h008;
    localparam logic [11:0] INC_BASE_WAIT      = 12'h010;
    localparam logic [11:0] MAX_WAIT           = 12'h800;
    localparam logic [2:0]  QUIRK_CODE         = 3'h5;
    localparam logic [11:0] QUIRK_INC_WAIT     = 12'h400;

    // Monitoring-cycle timebase
    localparam int          CLK_PERIOD_NS      = 50;
    localparam int          MONITOR_CYCLE_NS   = 125000000;
    localparam int          MONITOR_CYCLE_CLKS = MONITOR_CYCLE_NS / CLK_PERIOD_NS;
endpackage

/* pkg/pacer_if.sv */
// Signals between the register block and one channel pacer
`timescale 1ns/10ps
interface pacer_if;
    logic       tick;
    logic       enable;
    logic [2:0] code;
    logic       adjust_done;
    logic       dec_ok;
    logic       inc_ok;

    modport ctrl  (output tick, output enable, output code, output adjust_done,
                   input dec_ok, input inc_ok);
    modport pacer (input tick, input enable, input code, input adjust_done,
                   output dec_ok, output inc_ok);
endinterface

/* src/cycle_tick.sv */
// Monitoring-cycle tick generator
`timescale 1ns/10ps
module cycle_tick #(
    parameter int unsigned PERIOD = 2500000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // One-cycle pulse per monitoring cycle
    output logic      tick
);
    localparam int W = $clog2(PERIOD + 1);
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    logic [W-1:0] count;
    wire          wrap = (count == LAST);

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= wrap ? '0 : count + W'(1);
            tick  <= wrap;
        end
    end

    a_tick_period: assert property (@(posedge clk) disable iff (rst)
        $rose(tick) |-> count == '0) // R9
        else $error("tick not aligned to counter wrap");
endmodule

/* src/channel_pacer.sv */
// Per-channel adjustment wait counter
`timescale 1ns/10ps
module channel_pacer #(
    parameter bit IRREGULAR_INC = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control side
    pacer_if.pacer    pif
);
    logic [11:0] count;
    logic [11:0] next_count;

    wire [11:0] dec_wait = 12'(tmin_pacing_pkg::DEC_BASE_WAIT << pif.code); // R2
    wire        quirk    = IRREGULAR_INC && (pif.code == tmin_pacing_pkg::QUIRK_CODE);
    wire [11:0] inc_wait = quirk ? tmin_pacing_pkg::QUIRK_INC_WAIT // R4
                                 : 12'(tmin_pacing_pkg::INC_BASE_WAIT << pif.code); // R2
    wire        restart  = !pif.enable || pif.adjust_done; // R8 R9
    wire        advance  = pif.tick && (count != tmin_pacing_pkg::MAX_WAIT);

    // Count saturates at the longest wait so it never wraps back to zero
    assign next_count = restart ? 12'h000 : (advance ? count + 12'h001 : count); // R9

    always_ff @(posedge clk) begin
        if (rst) begin
            count      <= 12'h000;
            pif.dec_ok <= 1'b0;
            pif.inc_ok <= 1'b0;
        end else begin
            count      <= next_count;
            pif.dec_ok <= !restart && (next_count >= dec_wait); // R1 R3
            pif.inc_ok <= !restart && (next_count >= inc_wait); // R1 R3
        end
    end

    a_restart_adjust: assert property (@(posedge clk) disable iff (rst)
        pif.adjust_done |=> count == 12'h000 && !pif.dec_ok && !pif.inc_ok) // R9
        else $error("wait not restarted after adjustment");
    a_disable_holds: assert property (@(posedge clk) disable iff (rst)
        !pif.enable [*2] |-> !pif.dec_ok && !pif.inc_ok) // R8
        else $error("permission given while disabled");
    // Code must hold two edges: a shorter code may raise a flag past its wait
    a_dec_exact: assert property (@(posedge clk) disable iff (rst) // R1
        $rose(pif.dec_ok) && pif.code == $past(pif.code) && pif.code == $past(pif.code, 2)
        |-> count == dec_wait)
        else $error("decrease permission at wrong count");
    a_inc_exact: assert property (@(posedge clk) disable iff (rst) // R2
        $rose(pif.inc_ok) && pif.code == $past(pif.code) && pif.code == $past(pif.code, 2)
        |-> count == inc_wait)
        else $error("increase permission at wrong count");
    a_code0_waits: assert property (@(posedge clk) disable iff (rst) // R2
        pif.code == 3'h0 && pif.code == $past(pif.code) && pif.code == $past(pif.code, 2)
        && $rose(pif.dec_ok) |-> count == 12'h008)
        else $error("code 0 decrease wait not 8");
    a_quirk_wait: assert property (@(posedge clk) disable iff (rst) // R4
        IRREGULAR_INC && pif.code == 3'h5 && pif.code == $past(pif.code)
        && pif.code == $past(pif.code, 2) && $rose(pif.inc_ok)
        |-> count == 12'h400)
        else $error("second channel code 5 increase wait not 1024");
    a_no_tick_hold: assert property (@(posedge clk) disable iff (rst)
        !pif.tick && !restart |=> $stable(count)) // R9
        else $error("count moved without a monitoring cycle");
endmodule

/* src/tmin_pacing.sv */
// Dynamic minimum-temperature pacing block with Avalon-MM register slave
// Contract
// R1 - Bits 2:0 set remote 1 wait, in monitoring cycles, between adjustments.
// R2 - Remote 1 codes: decrease 8..1024, increase 16..2048 cycles, doubling.
// R3 - Bits 5:3 set remote 2 wait, in monitoring cycles, between adjustments.
// R4 - Remote 2 decrease like remote 1; increase code 101 gives 1024 cycles.
// R5 - Bit 6 selects loop: 0 legacy, 1 dynamic, 1 after reset.
// R6 - Bit 7 is reserved, reads zero, writes ignored.
// R7 - Software picks waits after measuring the system thermal time constants.
// R8 - Each remote channel paces only while its own enable bit is set.
// R9 - Waits count whole 125 ms monitoring cycles, restarting after each adjustment.
`timescale 1ns/10ps
module tmin_pacing #(
    parameter int unsigned MONITOR_CYCLE_CLKS = tmin_pacing_pkg::MONITOR_CYCLE_CLKS
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Control loop side
    input  wire logic [1:0]  adjust_done,
    output logic      [1:0]  decrease_allowed,
    output logic      [1:0]  increase_allowed,
    output logic      [1:0]  dynamic_enable,
    output logic             loop_select
);
    logic [7:0] enable_cfg;
    logic [7:0] pacing_cfg;
    logic       tick;
    logic [1:0] dec_ok;
    logic [1:0] inc_ok;

    pacer_if pif [2] ();

    // Bus decode; the slave answers one cycle after the request is seen
    wire        request    = read || write;
    wire        commit     = write && !waitrequest && byteenable[0];
    wire        hit_enable = (address == tmin_pacing_pkg::ENABLE_OFFSET);
    wire        hit_pacing = (address == tmin_pacing_pkg::PACING_OFFSET);
    wire        hit_status = (address == tmin_pacing_pkg::STATUS_OFFSET);
    wire [7:0]  status     = {4'h0, inc_ok, dec_ok};
    wire [7:0]  next_enable_cfg = writedata[7:0] & tmin_pacing_pkg::ENABLE_WRITE_MASK;
    // Reserved bit masked off so it always reads back as zero
    wire [7:0]  next_pacing_cfg = writedata[7:0] & tmin_pacing_pkg::PACING_WRITE_MASK; // R6
    wire [7:0]  read_byte  = hit_enable ? enable_cfg :
                             hit_pacing ? pacing_cfg :
                             hit_status ? status     : 8'h00;
    wire [31:0] next_readdata = {24'h000000, read_byte};

    always_ff @(posedge clk) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
        end else begin
            waitrequest <= !(waitrequest && request);
            readdata    <= (waitrequest && read) ? next_readdata : readdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            enable_cfg <= tmin_pacing_pkg::ENABLE_RESET;
            pacing_cfg <= tmin_pacing_pkg::PACING_RESET; // R5
        end else begin
            if (commit && hit_enable) begin
                enable_cfg <= next_enable_cfg; // R8
            end
            if (commit && hit_pacing) begin
                pacing_cfg <= next_pacing_cfg; // R1 R3 R5 R6
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            decrease_allowed <= 2'h0;
            increase_allowed <= 2'h0;
            dynamic_enable   <= 2'h0;
            loop_select      <= 1'b1;
        end else begin
            decrease_allowed <= dec_ok;
            increase_allowed <= inc_ok;
            dynamic_enable   <= {enable_cfg[tmin_pacing_pkg::REMOTE2_EN_BIT],
                                 enable_cfg[tmin_pacing_pkg::REMOTE1_EN_BIT]};
            loop_select      <= pacing_cfg[tmin_pacing_pkg::LOOP_SELECT_BIT]; // R5
        end
    end

    cycle_tick #(
        .PERIOD (MONITOR_CYCLE_CLKS)
    ) u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    ); // R9

    // Second channel carries the irregular increase entry
    for (genvar g = 0; g < 2; g++) begin : g_chan
        localparam int LSB = (g == 0) ? tmin_pacing_pkg::REMOTE1_INT_LSB
                                      : tmin_pacing_pkg::REMOTE2_INT_LSB;
        localparam int EN  = (g == 0) ? tmin_pacing_pkg::REMOTE1_EN_BIT
                                      : tmin_pacing_pkg::REMOTE2_EN_BIT;
        assign pif[g].tick        = tick;
        assign pif[g].enable      = enable_cfg[EN]; // R8
        assign pif[g].code        = pacing_cfg[LSB +: tmin_pacing_pkg::INTERVAL_W]; // R1 R3
        assign pif[g].adjust_done = adjust_done[g];
        assign dec_ok[g]          = pif[g].dec_ok;
        assign inc_ok[g]          = pif[g].inc_ok;
        channel_pacer #(
            .IRREGULAR_INC (g == 1)
        ) u_pacer (
            .clk (clk),
            .rst (rst),
            .pif (pif[g])
        ); // R4
    end

    sequence s_released;
        $fell(rst);
    endsequence
    sequence s_pacing_write;
        write && !waitrequest && byteenable[0] && address == 4'h4;
    endsequence

    a_reset_default: assert property (@(posedge clk)
        s_released |-> pacing_cfg == 8'h40 ##1 loop_select) // R5
        else $error("dynamic loop not selected after reset");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        !pacing_cfg[7] && !readdata[7] || !$past(hit_pacing)) // R6
        else $error("reserved bit not zero");
    // Loop select checked against the written bit, so a back-to-back write cannot mask it
    a_pacing_write: assert property (@(posedge clk) disable iff (rst) // R1 R3 R5
        s_pacing_write |=> pacing_cfg == {1'b0, $past(writedata[6:0])} ##1
        loop_select == $past(writedata[6], 2))
        else $error("pacing write not applied");
    a_answer_once: assert property (@(posedge clk) disable iff (rst)
        request && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("slave answer not one cycle wide");
    a_enable_gate: assert property (@(posedge clk) disable iff (rst)
        !enable_cfg[0] [*3] |-> !decrease_allowed[0] && !increase_allowed[0]) // R8
        else $error("remote 1 permission while disabled");
endmodule

/* verif/testbench.sv */
// Self-checking bench for the minimum-temperature pacing block
`timescale 1ns/10ps
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    localparam int TICK = 4;
    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic [3:0]  address     = 4'h0;
    logic        read        = 1'b0;
    logic        write       = 1'b0;
    logic [31:0] writedata   = 32'h0;
    logic [3:0]  byteenable  = 4'h0;
    logic [1:0]  adjust_done = 2'b00;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  decrease_allowed;
    logic [1:0]  increase_allowed;
    logic [1:0]  dynamic_enable;
    logic        loop_select;
    logic [31:0] seed        = 32'hffff;
    logic [31:0] rdata;
    logic [7:0]  r;
    int          fail_count  = 0;
    int          checks      = 0;
    int          cycles      = 0;

    // Short monitoring cycle keeps the longest wait near 8k clocks
    tmin_pacing #(.MONITOR_CYCLE_CLKS(TICK)) u_dut (
        .clk              (clk),
        .rst              (rst),
        .address          (address),
        .read             (read),
        .write            (write),
        .writedata        (writedata),
        .byteenable       (byteenable),
        .readdata         (readdata),
        .waitrequest      (waitrequest),
        .adjust_done      (adjust_done),
        .decrease_allowed (decrease_allowed),
        .increase_allowed (increase_allowed),
        .dynamic_enable   (dynamic_enable),
        .loop_select      (loop_select)
    );

    always #25 clk = ~clk;

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int dec_wait(input logic [2:0] code);
        return 8 << code;
    endfunction

    // Second channel repeats 1024 at code 5 instead of 512
    function automatic int inc_wait(input int ch, input logic [2:0] code);
        return (ch == 1 && code == 3'h5) ? 1024 : 16 << code;
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One Avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       input logic be);
        @(posedge clk);
        address    <= a;
        write      <= wr;
        read       <= !wr;
        writedata  <= {24'h0, d};
        byteenable <= {3'h0, be};
        @(posedge clk);
        while (waitrequest !== 1'b0) @(posedge clk);
        rdata = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask

    // Restart both waits, then time each allowed flag in monitoring cycles
    task automatic pace(input logic [2:0] c1, input logic [2:0] c2);
        int         rise [4];
        logic [3:0] flags;
        logic [31:0] rv;
        rv = xorshift();
        rise = '{default: 0};
        bus(1'b1, 4'h4, {rv[7:6], c2, c1}, 1'b1);
        bus(1'b1, 4'h0, 8'h03, 1'b1);
        @(posedge clk);
        adjust_done <= 2'b11;
        @(posedge clk);
        adjust_done <= 2'b00;
        for (int t = 1; t <= 9000; t++) begin
            @(posedge clk);
            #1;
            flags = {increase_allowed, decrease_allowed};
            if (t == 3) `CHECK(flags, 4'h0)
            for (int k = 0; k < 4; k++)
                if (t > 3 && rise[k] == 0 && flags[k] === 1'b1) rise[k] = t;
            if (rise[0] > 0 && rise[1] > 0 && rise[2] > 0 && rise[3] > 0) break;
        end
        // Tick phase is free: a wait of W cycles shows 4W-2 to 4W+1 clocks after restart
        `CHECK((rise[0] + 2) / TICK, dec_wait(c1))
        `CHECK((rise[1] + 2) / TICK, dec_wait(c2))
        `CHECK((rise[2] + 2) / TICK, inc_wait(0, c1))
        `CHECK((rise[3] + 2) / TICK, inc_wait(1, c2))
        bus(1'b0, 4'h8, 8'h00, 1'b0);
        `CHECK(rdata, 32'hf)
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 4'h4, 8'h00, 1'b0);
        `CHECK(rdata, 32'h40)
        `CHECK(loop_select, 1'b1)
        bus(1'b0, 4'h0, 8'h00, 1'b0);
        `CHECK(rdata, 32'h0)
        for (int i = 0; i < 6; i++) begin
            r = (i == 0) ? 8'hff : (i == 1) ? 8'h80 : 8'(xorshift());
            bus(1'b1, 4'h4, r, 1'b1);
            bus(1'b0, 4'h4, 8'h00, 1'b0);
            `CHECK(rdata, {24'h0, r & 8'h7f})
            `CHECK(loop_select, r[6])
        end
        // Disabled byte lane and unmapped address must leave the register alone
        bus(1'b1, 4'h4, ~r, 1'b0);
        bus(1'b1, 4'hc, ~r, 1'b1);
        bus(1'b0, 4'hc, 8'h00, 1'b0);
        `CHECK(rdata, 32'h0)
        bus(1'b0, 4'h4, 8'h00, 1'b0);
        `CHECK(rdata, {24'h0, r & 8'h7f})
        $display("register test done");
        for (int i = 0; i < 8; i++) pace(i[2:0], 3'h7 - i[2:0]);
        r = 8'(xorshift());
        pace(r[2:0], r[5:3]);
        $display("pacing test done");
        bus(1'b1, 4'h0, 8'h00, 1'b1);
        repeat (20) @(posedge clk);
        `CHECK({increase_allowed, decrease_allowed}, 4'h0)
        `CHECK(dynamic_enable, 2'b00)
        bus(1'b1, 4'h4, 8'h40, 1'b1);
        bus(1'b1, 4'h0, 8'h01, 1'b1);
        repeat (40) @(posedge clk);
        `CHECK({increase_allowed, decrease_allowed}, 4'h1)
        `CHECK(dynamic_enable, 2'b01)
        adjust_done <= 2'b01;
        @(posedge clk);
        adjust_done <= 2'b00;
        repeat (3) @(posedge clk);
        `CHECK({increase_allowed, decrease_allowed}, 4'h0)
        $display("enable test done");
        finish_test();
    end
endmodule
